// [verif/dac_cfg_bank_monitor.sv]
// concurrent checks on the ports of the converter configuration register bank
module dac_cfg_bank_monitor #(
   parameter logic [2:0] PART_IDENTITY = 3'h6, // arbitrary value
   parameter logic [1:0] REG_REVISION  = 2'h0  // arbitrary value
) (
   input wire logic                        core_clk_i,
   input wire logic                        rst_i,
   input wire logic                        wr_en_i,
   input wire logic                        rd_en_i,
   input wire logic [3:0]                  addr_i,
   input wire logic [7:0]                  wdata_i,
   input wire logic                        fifo_overrun_i,
   input wire logic [7:0]                  rdata_o,
   input wire logic                        sync_pulse_o,
   input wire logic                        fifo_realign_o,
   input wire dac_cfg_pkg::datapath_ctrl_s ctrl_o,
   input wire logic [15:0][7:0]            regs_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------------------------
   // port relations
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence status_rd_s;
      rd_en_i && addr_i == 4'h0;
   endsequence
   // soft bit rising: write sets it while the register still holds zero
   sequence soft_rise_s;
      wr_en_i && addr_i == 4'h3 && wdata_i[1] && !regs_o[3][1];
   endsequence
   AST_PART_ID: assert property (status_rd_s |=> rdata_o[5:2] == {1'b0, PART_IDENTITY})
      else $error("part identity field wrong");
   AST_REVISION: assert property (status_rd_s |=> rdata_o[1:0] == REG_REVISION)
      else $error("revision field wrong");
   AST_DLL_RESTART: assert property (status_rd_s ##0 regs_o[8][2] |=> !rdata_o[6])
      else $error("delay loop lock shown during restart");
   AST_SWAP: assert property (wr_en_i && addr_i == 4'h3 |=> ctrl_o.swap_channel_outputs ==
      $past(wdata_i[3]) && ctrl_o.mirror_a_to_b == $past(wdata_i[2])) else $error("routing bits");
   AST_FIFO_SET: assert property (fifo_overrun_i && !regs_o[3][5] |=> regs_o[4][5])
      else $error("fifo error not recorded");
   AST_MASKED: assert property (!regs_o[4][5] && !(fifo_overrun_i && !regs_o[3][5])
      |=> !regs_o[4][5]) else $error("fifo error set without unmasked event");
   AST_STICKY: assert property (regs_o[4][5] && !(wr_en_i && addr_i == 4'h4 && !wdata_i[5])
      |=> regs_o[4][5]) else $error("fifo error dropped without clearing write");
   AST_SOFT_SYNC: assert property (soft_rise_s |=> ##1 sync_pulse_o)
      else $error("soft sync gave no sync pulse");
   AST_REALIGN: assert property (sync_pulse_o && $stable(regs_o[5])
      |-> fifo_realign_o == !regs_o[5][4]) else $error("fifo realign pulse wrong");
endmodule

bind dac_config_register_bank dac_cfg_bank_monitor #(
   .PART_IDENTITY(PART_IDENTITY), .REG_REVISION(REG_REVISION)) i_dac_cfg_bank_monitor (
   .core_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .fifo_overrun_i,
   .rdata_o, .sync_pulse_o, .fifo_realign_o, .ctrl_o, .regs_o);

// [verif/testbench.sv]
// self-checking bench for the converter configuration register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import dac_cfg_pkg::*;
   // -------------------------------------------------------------
   // hookup and model state
   // -------------------------------------------------------------
   localparam logic [2:0] PART_ID = 3'h5; // arbitrary value
   localparam logic [1:0] REV     = 2'h0; // arbitrary value
   localparam logic [7:0] RST_TAB [16] = '{8'h00, 8'h10, 8'hc0, 8'h70, 8'h00, 8'h00, 8'h0c,
      8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic                 core_clk_i = 1'b0;
   logic                 rst_i      = 1'b1;
   logic                 wr_en_i    = 1'b0;
   logic                 rd_en_i    = 1'b0;
   logic [3:0]           addr_i     = 4'h0;
   logic [7:0]           wdata_i    = 8'h00;
   logic [5:0]           pins       = 6'h00; // pll, dll, sync, overrun, self fail, pattern
   logic [7:0]           rdata_o;
   logic                 sync_pulse_o;
   logic                 fifo_realign_o;
   datapath_ctrl_s       ctrl_o;
   logic [15:0][7:0]     regs_o;
   logic [7:0]           model [16];
   logic [31:0]          seed       = 32'h0000_7c60;
   int                   mismatches = 0;
   int                   tests_run  = 0;
   dac_config_register_bank #(.PART_IDENTITY(PART_ID), .REG_REVISION(REV))
   i_dac_config_register_bank (.core_clk_i, .rst_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
      .pll_lock_i(pins[5]), .dll_lock_i(pins[4]), .ext_sync_i(pins[3]),
      .fifo_overrun_i(pins[2]), .self_check_fail_i(pins[1]), .pattern_mismatch_i(pins[0]),
      .rdata_o, .sync_pulse_o, .fifo_realign_o, .ctrl_o, .regs_o);
   always #20 core_clk_i = ~core_clk_i;
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] stat();
      return {pins[5], pins[4] & ~model[8][2], 1'b0, PART_ID, REV};
   endfunction
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // status writes vanish; the flag register only takes clearing zeros
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
      @(negedge core_clk_i);
      wr_en_i = 1'b0;
      if (a == ERROR_FLAGS_OFS) model[4] = model[4] & (d | 8'h8f);
      else if (a != LOCK_IDENTITY_STATUS_OFS) model[a] = d & WRITE_MASKS[a];
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      {rd_en_i, addr_i} = {1'b1, a};
      @(negedge core_clk_i);
      rd_en_i = 1'b0;
      d = rdata_o;
   endtask
   task automatic events(input logic [2:0] v);
      @(negedge core_clk_i);
      pins[2:0] = v;
      @(negedge core_clk_i);
      pins[2:0] = 3'b000;
      if (v[2] && !model[3][5]) model[4][5] = 1'b1;
      if (v[1] && !model[3][6] && model[1][3]) model[4][6] = 1'b1;
      if (v[0] && !model[3][4]) model[4][4] = 1'b1;
   endtask
   task automatic sync_seen(input logic want, input logic realign);
      logic seen = 1'b0;
      logic re = 1'b0;
      repeat (12) begin
         @(negedge core_clk_i);
         if (sync_pulse_o === 1'b1) {seen, re} = {1'b1, fifo_realign_o};
      end
      check(seen, want);
      check(re, realign);
   endtask
   // status read last, so the lock filter has long settled
   task automatic check_all();
      logic [7:0] d;
      datapath_ctrl_s c;
      for (int i = 15; i >= 0; i--) begin
         rd(4'(i), d);
         check(d, (i == 0) ? stat() : model[i]);
         check(regs_o[i], (i == 0) ? 8'h00 : model[i]);
      end
      c = '{model[1][7:6], model[1][4], model[1][3], model[1][2:0], model[2][7], model[2][6],
         model[2][5], mix_mode_e'(model[2][3:2]), mix_mode_e'(model[2][1:0]), model[3][7],
         model[3][3], model[3][2], {model[12][4:0], model[13]}, {model[14][4:0], model[15]}};
      check(ctrl_o[42:33], c[42:33]);
      check(ctrl_o[32:0], c[32:0]);
   endtask
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      logic [7:0] r;
      model = RST_TAB;
      repeat (10) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_i = 1'b0;
      check_all();
      pins[5:4] = 2'b11;
      wr(DELAY_LOOP_RESTART_CTRL_OFS, 8'hff);
      check_all();
      wr(LOCK_IDENTITY_STATUS_OFS, 8'hff);
      for (int n = 0; n < 80; n++) begin
         r = xs();
         wr(r[3:0], xs());
         if (n % 20 == 19) check_all();
      end
      wr(ERROR_FLAGS_OFS, 8'h00);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h70);
      wr(DELAY_FILTER_FIFO_CTRL_OFS, 8'h10);
      events(3'b111);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h00);
      events(3'b010);
      check_all();
      wr(DELAY_FILTER_FIFO_CTRL_OFS, 8'h18);
      events(3'b111);
      wr(ERROR_FLAGS_OFS, 8'hdf);
      check_all();
      wr(BUS_BYPASS_CTRL_OFS, 8'h00);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h73);
      sync_seen(1'b1, 1'b1);
      wr(BUS_BYPASS_CTRL_OFS, 8'h10);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h71);
      sync_seen(1'b0, 1'b0);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h73);
      sync_seen(1'b1, 1'b0);
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h71);
      pins[3] = 1'b1;
      sync_seen(1'b0, 1'b0);
      pins[3] = 1'b0;
      wr(OFFSET_MASK_ROUTING_CTRL_OFS, 8'h70);
      repeat (8) @(negedge core_clk_i);
      pins[3] = 1'b1;
      sync_seen(1'b1, 1'b0);
      {pins[5], pins[3], rst_i} = 3'b001;
      @(negedge core_clk_i);
      rst_i = 1'b0;
      model = RST_TAB;
      check_all();
      tally_and_finish();
   end
   // a hang ends the run as a failure
   initial begin
      #400000;
      mismatches++;
      tally_and_finish();
   end
endmodule

// [verilog/dac_cfg_pkg.sv]
// shared constants and carrier types of the converter configuration register bank
package dac_cfg_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] LOCK_IDENTITY_STATUS_OFS     = 4'h0;
   localparam logic [3:0] DELAY_FILTER_FIFO_CTRL_OFS   = 4'h1;
   localparam logic [3:0] FORMAT_INTERP_MIXER_CTRL_OFS = 4'h2;
   localparam logic [3:0] OFFSET_MASK_ROUTING_CTRL_OFS = 4'h3;
   localparam logic [3:0] ERROR_FLAGS_OFS              = 4'h4;
   localparam logic [3:0] BUS_BYPASS_CTRL_OFS          = 4'h5;
   localparam logic [3:0] POWER_SLEEP_CTRL_OFS         = 4'h6;
   localparam logic [3:0] OUTPUT_GAIN_CTRL_OFS         = 4'h7;
   localparam logic [3:0] DELAY_LOOP_RESTART_CTRL_OFS  = 4'h8;
   localparam logic [3:0] PLL_DIVIDER_CTRL_OFS         = 4'h9;
   localparam logic [3:0] DELAY_LOOP_TUNING_CTRL_OFS   = 4'ha;
   localparam logic [3:0] PLL_LOOP_CTRL_OFS            = 4'hb;
   localparam logic [3:0] OFFSET_A_HIGH_OFS            = 4'hc;
   localparam logic [3:0] OFFSET_A_LOW_OFS             = 4'hd;
   localparam logic [3:0] SERIAL_OUT_SELECT_CTRL_OFS   = 4'he;
   localparam logic [3:0] OFFSET_B_LOW_OFS             = 4'hf;

   // ---------------------------------------------------------------
   // reset values, one byte per offset 0x0 .. 0xf
   // ---------------------------------------------------------------
   localparam logic [15:0][7:0] RESET_VALUES = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'h0c, 8'h00, 8'h00, 8'h70, 8'hc0, 8'h10, 8'h00};

   // writable bits per offset; unused and reserved bits stay zero
   localparam logic [15:0][7:0] WRITE_MASKS = {
      8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h04,
      8'hff, 8'hbf, 8'hf6, 8'h00, 8'hff, 8'hef, 8'hdf, 8'h00};

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PLL_LOCK_BIT        = 7;
   localparam int DLL_LOCK_BIT        = 6;
   localparam int PART_ID_LSB         = 2;
   localparam int DELAY_LSB           = 6;
   localparam int FILTER_ENABLE_BIT   = 4;
   localparam int SELF_CHECK_EN_BIT   = 3;
   localparam int FIFO_OFFSET_LSB     = 0;
   localparam int TWOS_COMP_BIT       = 7;
   localparam int DUAL_CONV_BIT       = 6;
   localparam int INTERP_FACTOR_BIT   = 5;
   localparam int FINAL_MODE_LSB      = 2;
   localparam int FIRST_MODE_LSB      = 0;
   localparam int OFFSET_ENABLE_BIT   = 7;
   localparam int SELF_CHECK_MASK_BIT = 6;
   localparam int FIFO_ERR_MASK_BIT   = 5;
   localparam int PATTERN_MASK_BIT    = 4;
   localparam int SWAP_BIT            = 3;
   localparam int MIRROR_BIT          = 2;
   localparam int SOFT_SYNC_BIT       = 1;
   localparam int SOFT_SYNC_SEL_BIT   = 0;
   localparam int SELF_CHECK_ERR_BIT  = 6;
   localparam int FIFO_ERR_BIT        = 5;
   localparam int PATTERN_ERR_BIT     = 4;
   localparam int FIFO_SYNC_DIS_BIT   = 4;
   localparam int DLL_RESTART_BIT     = 2;
   localparam int OFFSET_HIGH_W       = 5;

   // final and first mixer stage encodings
   typedef enum logic [1:0] {
      MIX_LOW_PASS  = 2'b00,
      MIX_HIGH_PASS = 2'b01,
      MIX_PLUS      = 2'b10,
      MIX_MINUS     = 2'b11
   } mix_mode_e;

   // control fields that steer the datapath
   typedef struct packed {
      logic [1:0]  sample_delay;
      logic        filter_enable;
      logic        core_self_check_enable;
      logic [2:0]  fifo_offset;
      logic        twos_complement;
      logic        dual_converter;
      logic        interp_factor_select;
      mix_mode_e   final_stage_mode;
      mix_mode_e   first_stage_mode;
      logic        offset_enable;
      logic        swap_channel_outputs;
      logic        mirror_a_to_b;
      logic [12:0] channel_a_offset_value;
      logic [12:0] channel_b_offset_value;
   } datapath_ctrl_s;

endpackage

// [verilog/dac_config_register_bank.sv]
// configuration and status register bank of the dual-channel interpolating converter

module dac_config_register_bank #(
   parameter logic [2:0] PART_IDENTITY = 3'h6, // arbitrary value
   parameter logic [1:0] REG_REVISION  = 2'h0  // arbitrary value
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          wr_en_i,
   input  wire logic                          rd_en_i,
   input  wire logic [3:0]                    addr_i,
   input  wire logic [7:0]                    wdata_i,
   input  wire logic                          pll_lock_i,
   input  wire logic                          dll_lock_i,
   input  wire logic                          ext_sync_i,
   input  wire logic                          fifo_overrun_i,
   input  wire logic                          self_check_fail_i,
   input  wire logic                          pattern_mismatch_i,
   output logic      [7:0]                    rdata_o,
   output logic                               sync_pulse_o,
   output logic                               fifo_realign_o,
   output dac_cfg_pkg::datapath_ctrl_s        ctrl_o,
   output logic      [15:0][7:0]              regs_o
);
   import dac_cfg_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0][7:0] regs;
      logic [2:0]       pll_sync;
      logic [2:0]       dll_sync;
      logic [2:0]       ext_sync;
      logic             pll_lock;
      logic             dll_lock;
      logic             ext_sync_lvl;
      logic             ext_sync_prev;
      logic             soft_sync_prev;
      logic [7:0]       rdata;
      logic             sync_pulse;
      logic             fifo_realign;
   } bank_state_s;

   bank_state_s state_ff;
   bank_state_s nxt_state;

   logic [7:0] status_byte;
   logic       sync_event;
   logic       soft_sel;
   logic       ext_rise;
   logic       soft_rise;
   logic       clear_wr;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // three-stage pin capture; a change counts once stages two and three agree
      nxt_state.pll_sync = {state_ff.pll_sync[1:0], pll_lock_i};
      nxt_state.dll_sync = {state_ff.dll_sync[1:0], dll_lock_i};
      nxt_state.ext_sync = {state_ff.ext_sync[1:0], ext_sync_i};
      if (state_ff.pll_sync[1] == state_ff.pll_sync[2]) begin
         nxt_state.pll_lock = state_ff.pll_sync[2];
      end
      if (state_ff.dll_sync[1] == state_ff.dll_sync[2]) begin
         nxt_state.dll_lock = state_ff.dll_sync[2];
      end
      if (state_ff.ext_sync[1] == state_ff.ext_sync[2]) begin
         nxt_state.ext_sync_lvl = state_ff.ext_sync[2];
      end

      // a loop restart holds the delay loop flag low for as long as the restart bit stays set
      if (state_ff.regs[DELAY_LOOP_RESTART_CTRL_OFS][DLL_RESTART_BIT]) begin
         nxt_state.dll_lock = 1'b0;
      end

      // status byte is built live and never stored
      status_byte = 8'h00;
      status_byte[PLL_LOCK_BIT] = state_ff.pll_lock;
      // masked live as well, so a read right after a restart write never shows lock
      status_byte[DLL_LOCK_BIT] = state_ff.dll_lock
         && !state_ff.regs[DELAY_LOOP_RESTART_CTRL_OFS][DLL_RESTART_BIT];
      status_byte[PART_ID_LSB +: 3] = PART_IDENTITY;
      status_byte[1:0] = REG_REVISION;

      // register writes; offset 0 has an all-zero mask so writes vanish
      clear_wr = wr_en_i && (addr_i == ERROR_FLAGS_OFS);
      if (wr_en_i && !clear_wr) begin
         nxt_state.regs[addr_i] = wdata_i & WRITE_MASKS[addr_i];
      end

      // error flags: a zero written clears, a one is ignored
      if (clear_wr) begin
         // the flag byte has an all-zero load mask, so only the and with the data clears
         nxt_state.regs[ERROR_FLAGS_OFS] = state_ff.regs[ERROR_FLAGS_OFS] & wdata_i;
      end

      // events set after the clear so a same-cycle event survives it
      if (self_check_fail_i
          && state_ff.regs[DELAY_FILTER_FIFO_CTRL_OFS][SELF_CHECK_EN_BIT]
          && !state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][SELF_CHECK_MASK_BIT]) begin
         nxt_state.regs[ERROR_FLAGS_OFS][SELF_CHECK_ERR_BIT] = 1'b1;
      end
      if (fifo_overrun_i
          && !state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][FIFO_ERR_MASK_BIT]) begin
         nxt_state.regs[ERROR_FLAGS_OFS][FIFO_ERR_BIT] = 1'b1;
      end
      if (pattern_mismatch_i
          && !state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][PATTERN_MASK_BIT]) begin
         nxt_state.regs[ERROR_FLAGS_OFS][PATTERN_ERR_BIT] = 1'b1;
      end

      // read data, registered; one cycle after the read strobe
      if (rd_en_i) begin
         if (addr_i == LOCK_IDENTITY_STATUS_OFS) begin
            nxt_state.rdata = status_byte;
         end else begin
            nxt_state.rdata = state_ff.regs[addr_i];
         end
      end

      // sync source: soft select takes the software bit alone
      soft_sel  = state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][SOFT_SYNC_SEL_BIT];
      ext_rise  = state_ff.ext_sync_lvl && !state_ff.ext_sync_prev;
      soft_rise = state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][SOFT_SYNC_BIT]
                  && !state_ff.soft_sync_prev;
      sync_event = soft_sel ? soft_rise : (soft_rise || ext_rise);
      nxt_state.ext_sync_prev  = state_ff.ext_sync_lvl;
      nxt_state.soft_sync_prev = state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][SOFT_SYNC_BIT];
      nxt_state.sync_pulse = sync_event;
      // realignment is skipped while fifo sync is disabled
      nxt_state.fifo_realign = sync_event
         && !state_ff.regs[BUS_BYPASS_CTRL_OFS][FIFO_SYNC_DIS_BIT];
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff      <= '0;
         state_ff.regs <= RESET_VALUES;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs, straight from the state register
   // ---------------------------------------------------------------
   assign rdata_o        = state_ff.rdata;
   assign sync_pulse_o   = state_ff.sync_pulse;
   assign fifo_realign_o = state_ff.fifo_realign;
   assign regs_o         = state_ff.regs;

   // fifo offset code is twos complement: 3 .. -4
   assign ctrl_o.sample_delay =
      state_ff.regs[DELAY_FILTER_FIFO_CTRL_OFS][DELAY_LSB +: 2];
   assign ctrl_o.filter_enable =
      state_ff.regs[DELAY_FILTER_FIFO_CTRL_OFS][FILTER_ENABLE_BIT];
   assign ctrl_o.core_self_check_enable =
      state_ff.regs[DELAY_FILTER_FIFO_CTRL_OFS][SELF_CHECK_EN_BIT];
   assign ctrl_o.fifo_offset =
      state_ff.regs[DELAY_FILTER_FIFO_CTRL_OFS][FIFO_OFFSET_LSB +: 3];
   assign ctrl_o.twos_complement =
      state_ff.regs[FORMAT_INTERP_MIXER_CTRL_OFS][TWOS_COMP_BIT];
   assign ctrl_o.dual_converter =
      state_ff.regs[FORMAT_INTERP_MIXER_CTRL_OFS][DUAL_CONV_BIT];
   assign ctrl_o.interp_factor_select =
      state_ff.regs[FORMAT_INTERP_MIXER_CTRL_OFS][INTERP_FACTOR_BIT];
   assign ctrl_o.final_stage_mode = mix_mode_e'(
      state_ff.regs[FORMAT_INTERP_MIXER_CTRL_OFS][FINAL_MODE_LSB +: 2]);
   assign ctrl_o.first_stage_mode = mix_mode_e'(
      state_ff.regs[FORMAT_INTERP_MIXER_CTRL_OFS][FIRST_MODE_LSB +: 2]);
   assign ctrl_o.offset_enable =
      state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][OFFSET_ENABLE_BIT];
   assign ctrl_o.swap_channel_outputs =
      state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][SWAP_BIT];
   assign ctrl_o.mirror_a_to_b =
      state_ff.regs[OFFSET_MASK_ROUTING_CTRL_OFS][MIRROR_BIT];
   assign ctrl_o.channel_a_offset_value = {
      state_ff.regs[OFFSET_A_HIGH_OFS][OFFSET_HIGH_W-1:0],
      state_ff.regs[OFFSET_A_LOW_OFS]};
   // upper part of the b offset shares the serial-out select byte
   assign ctrl_o.channel_b_offset_value = {
      state_ff.regs[SERIAL_OUT_SELECT_CTRL_OFS][OFFSET_HIGH_W-1:0],
      state_ff.regs[OFFSET_B_LOW_OFS]};

endmodule
